// ===== hw/wes_pkg.sv
// Constants, register map and types of the wake event and SMI logic
package wes_pkg;
  // Runtime register offsets
  localparam logic [7:0] OFF_EDGE_SEL = 8'h21;
  localparam logic [7:0] OFF_SCAN_CODE = 8'h5f;
  localparam logic [7:0] OFF_SLEEP_LOW = 8'h60;
  localparam logic [7:0] OFF_SLEEP_HIGH = 8'h61;
  localparam logic [7:0] OFF_SMI_STATUS_SEVEN = 8'h64;
  localparam logic [7:0] OFF_SMI_ENABLE_SEVEN = 8'h66;
  localparam logic [7:0] OFF_WAKE_CTRL = 8'h68;
  localparam logic [7:0] OFF_PIN_CFG = 8'h69;
  localparam logic [7:0] OFF_WAKE_STS1 = 8'h6a;
  localparam logic [7:0] OFF_WAKE_EN1 = 8'h6b;
  localparam logic [7:0] OFF_WAKE_STS2 = 8'h6c;
  localparam logic [7:0] OFF_WAKE_EN2 = 8'h6d;
  localparam logic [7:0] OFF_GPIO_POL = 8'h6e;
  localparam logic [7:0] OFF_GPIO_EITHER_EDGE_TRIGGER = 8'h6f;
  localparam logic [7:0] OFF_WAKE_STS6 = 8'h70;
  localparam logic [7:0] OFF_WAKE_EN6 = 8'h71;
  localparam logic [7:0] OFF_SLOW_CFG = 8'hf0;
  // Field positions
  localparam int SLEEP_EN_BIT = 5;
  localparam int SLEEP_TYPE_LSB = 2;
  localparam int SMI7_SLEEP_BIT = 5;
  localparam int EDGE_LINE_A_BIT = 0;
  localparam int EDGE_LINE_B_BIT = 1;
  localparam int CTRL_GLOBAL_EN_BIT = 0;
  localparam int CTRL_SUMMARY_BIT = 1;
  localparam int CTRL_SMI_A_BIT = 2;
  localparam int CTRL_SMI_B_BIT = 3;
  localparam int PIN_POL_BIT = 0;
  localparam int PIN_PUSH_PULL_BIT = 7;
  localparam int SLOW_PRESENT_BIT = 0;
  localparam int KEY_OFF_BIT = 1;
  localparam int S1_RING_BIT = 0;
  localparam int S1_LINE_A_BIT = 1;
  localparam int S1_LINE_B_BIT = 2;
  localparam int S1_WDT_BIT = 3;
  localparam int S1_TACH_BIT = 4;
  localparam int S1_KEY_BIT = 5;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_SCAN_CODE = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  // Timing
  localparam int unsigned REF_CLK_HZ = 40_000_000;
  localparam int unsigned SLOW_CLK_HZ = 32_768;
  localparam int unsigned SLOW_DIV_CYCLES = REF_CLK_HZ / SLOW_CLK_HZ;
  localparam int KEY_DATA_BITS = 8;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_DATA,
    KEY_PARITY,
    KEY_STOP
  } wes_key_e;
endpackage : wes_pkg

// ===== hw/wes_wake_event_smi.sv
// Wake event gathering, sleep-enable SMI and specific-key wake detection
// Behaviour
// - Sleep-enable write of one requests SMI
// - Sleep type field is inert storage
// - Two adjacent bytes form 16-bit control
// - Sleep write sets status; enable gates SMI
// - All listed sources can assert wake
// - Wake pin polarity and driver configurable
// - Global enable off blocks wake output
// - Enabled sources assert wake when global on
// - Summary set regardless of global enable
// - Status AND enable sets summary
// - Summary holds until pending events cleared
// - GPIO default polarity sets on rising
// - Either-edge GPIO; write-one clears status
// - Port lines falling or both edges
// - Both-edge lines keep setting until cleared
// - Port status write-one clear drops SMI
// - Register pairs grouped by source kind
// - Scan code on trickle power reset
// - Key match sets status one bit 5
// - Slow clock present selects key clock
// - Key-off bit gates the key logic
`timescale 1ns/10ps
module wes_wake_event_smi #(
  parameter int unsigned DIV_CYCLES = wes_pkg::SLOW_DIV_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic i_trickle_resetn,
  input wire logic i_clk_en,
  input wire logic [7:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  input wire logic i_ring_indicator_in_n,
  input wire logic i_kbd_port_line_a,
  input wire logic i_kbd_port_line_b,
  input wire logic i_wdt_timeout,
  input wire logic i_fan_tach_event,
  input wire logic [7:0] i_gpio,
  input wire logic [7:0] i_dev_irq,
  input wire logic i_kbd_clk,
  input wire logic i_kbd_data,
  input wire logic i_slow_clk_ext,
  output logic o_smi_req,
  output logic o_wake_event_out,
  output logic o_wake_event_oe_n
);
  // Divider counter is 11 bits wide
  if (DIV_CYCLES < 2 || DIV_CYCLES > 2047) begin : g_bad_div
    $error("DIV_CYCLES out of range");
  end

  typedef struct packed {
    logic [7:0] edge_sel;
    logic [7:0] sleep_low;
    logic [2:0] sleep_type;
    logic [7:0] smi_status_seven;
    logic [7:0] smi_enable_seven;
    logic [7:0] slow_cfg;
    logic [7:0] wake_ctrl;
    logic [7:0] pin_cfg;
    logic [7:0] sts1;
    logic [7:0] en1;
    logic [7:0] sts2;
    logic [7:0] en2;
    logic [7:0] gpio_pol;
    logic [7:0] gpio_either_edge_trigger;
    logic [7:0] sts6;
    logic [7:0] en6;
    logic summary;
    logic wake_act;
    logic pin_level;
    logic pin_oe_n;
    logic [7:0] rdata;
    logic [7:0] prev_gpio;
    logic [7:0] prev_irq;
    logic prev_ri;
    logic prev_la;
    logic prev_lb;
    logic prev_wdt;
    logic prev_tach;
    logic prev_ext;
    logic prev_kclk;
    logic [10:0] div;
    wes_pkg::wes_key_e kst;
    logic [2:0] kcnt;
    logic [7:0] kbyte;
  } wes_state_s;

  wes_state_s q;
  wes_state_s d;
  logic [7:0] scan_code_q;
  logic [7:0] gpio_set;
  logic [7:0] irq_set;
  logic [7:0] s1_set;
  logic slow_tick;
  logic kclk_fall;
  logic key_hit;
  logic [7:0] pending1;
  logic [7:0] pending2;
  logic [7:0] pending6;

  // GPIO edge: polarity picks rising or falling, either-edge overrides
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gpio
      assign gpio_set[gi] = q.gpio_either_edge_trigger[gi] ? (i_gpio[gi] ^ q.prev_gpio[gi]) :
        (q.gpio_pol[gi] ? (q.prev_gpio[gi] & ~i_gpio[gi]) :
        (~q.prev_gpio[gi] & i_gpio[gi]));
      assign irq_set[gi] = i_dev_irq[gi] & ~q.prev_irq[gi];
    end
  endgenerate

  // Ticks stop entirely when the key logic is off, though the divider keeps counting
  assign slow_tick = ~q.slow_cfg[wes_pkg::KEY_OFF_BIT] &
    (q.slow_cfg[wes_pkg::SLOW_PRESENT_BIT] ? (i_slow_clk_ext & ~q.prev_ext) :
    (q.div == 11'h000));
  assign kclk_fall = slow_tick & q.prev_kclk & ~i_kbd_clk;
  assign key_hit = kclk_fall && (q.kst == wes_pkg::KEY_STOP) && i_kbd_data &&
    (q.kbyte == scan_code_q);

  always_comb begin
    s1_set = 8'h00;
    s1_set[wes_pkg::S1_RING_BIT] = q.prev_ri & ~i_ring_indicator_in_n;
    s1_set[wes_pkg::S1_LINE_A_BIT] = q.edge_sel[wes_pkg::EDGE_LINE_A_BIT] ?
      (q.prev_la ^ i_kbd_port_line_a) : (q.prev_la & ~i_kbd_port_line_a);
    s1_set[wes_pkg::S1_LINE_B_BIT] = q.edge_sel[wes_pkg::EDGE_LINE_B_BIT] ?
      (q.prev_lb ^ i_kbd_port_line_b) : (q.prev_lb & ~i_kbd_port_line_b);
    s1_set[wes_pkg::S1_WDT_BIT] = i_wdt_timeout & ~q.prev_wdt;
    s1_set[wes_pkg::S1_TACH_BIT] = i_fan_tach_event & ~q.prev_tach;
    s1_set[wes_pkg::S1_KEY_BIT] = key_hit;
  end

  always_comb begin
    d = q;
    d.prev_gpio = i_gpio;
    d.prev_irq = i_dev_irq;
    d.prev_ri = i_ring_indicator_in_n;
    d.prev_la = i_kbd_port_line_a;
    d.prev_lb = i_kbd_port_line_b;
    d.prev_wdt = i_wdt_timeout;
    d.prev_tach = i_fan_tach_event;
    d.prev_ext = i_slow_clk_ext;
    d.div = (q.div == 11'h000) ? 11'(DIV_CYCLES - 1) : q.div - 11'h001;
    if (slow_tick) begin
      d.prev_kclk = i_kbd_clk;
    end
    if (q.slow_cfg[wes_pkg::KEY_OFF_BIT]) begin
      d.kst = wes_pkg::KEY_IDLE;
    end else if (kclk_fall) begin
      unique case (q.kst)
        wes_pkg::KEY_IDLE: begin
          if (!i_kbd_data) begin
            d.kst = wes_pkg::KEY_DATA;
            d.kcnt = 3'h0;
          end
        end
        wes_pkg::KEY_DATA: begin
          d.kbyte = {i_kbd_data, q.kbyte[7:1]};
          d.kcnt = q.kcnt + 3'h1;
          if (q.kcnt == 3'(wes_pkg::KEY_DATA_BITS - 1)) begin
            d.kst = wes_pkg::KEY_PARITY;
          end
        end
        wes_pkg::KEY_PARITY: begin
          d.kst = (^{q.kbyte, i_kbd_data}) ? wes_pkg::KEY_STOP : wes_pkg::KEY_IDLE;
        end
        wes_pkg::KEY_STOP: begin
          d.kst = wes_pkg::KEY_IDLE;
        end
      endcase
    end

    // Writes; hardware sets are ORed in after the clears so a set wins
    if (i_io_wr) begin
      unique case (i_io_addr)
        wes_pkg::OFF_EDGE_SEL: d.edge_sel = i_io_wdata;
        wes_pkg::OFF_SLEEP_LOW: d.sleep_low = i_io_wdata;
        wes_pkg::OFF_SLEEP_HIGH: d.sleep_type = i_io_wdata[wes_pkg::SLEEP_TYPE_LSB +: 3];
        wes_pkg::OFF_SMI_STATUS_SEVEN: d.smi_status_seven = q.smi_status_seven & ~i_io_wdata;
        wes_pkg::OFF_SMI_ENABLE_SEVEN: d.smi_enable_seven = i_io_wdata;
        wes_pkg::OFF_WAKE_CTRL: d.wake_ctrl = i_io_wdata & 8'h0d;
        wes_pkg::OFF_PIN_CFG: d.pin_cfg = i_io_wdata;
        wes_pkg::OFF_WAKE_STS1: d.sts1 = q.sts1 & ~i_io_wdata;
        wes_pkg::OFF_WAKE_EN1: d.en1 = i_io_wdata;
        wes_pkg::OFF_WAKE_STS2: d.sts2 = q.sts2 & ~i_io_wdata;
        wes_pkg::OFF_WAKE_EN2: d.en2 = i_io_wdata;
        wes_pkg::OFF_GPIO_POL: d.gpio_pol = i_io_wdata;
        wes_pkg::OFF_GPIO_EITHER_EDGE_TRIGGER: d.gpio_either_edge_trigger = i_io_wdata;
        wes_pkg::OFF_WAKE_STS6: d.sts6 = q.sts6 & ~i_io_wdata;
        wes_pkg::OFF_WAKE_EN6: d.en6 = i_io_wdata;
        wes_pkg::OFF_SLOW_CFG: d.slow_cfg = i_io_wdata;
        default: ;
      endcase
    end
    if (i_io_wr && i_io_addr == wes_pkg::OFF_SLEEP_HIGH && i_io_wdata[wes_pkg::SLEEP_EN_BIT]) begin
      d.smi_status_seven[wes_pkg::SMI7_SLEEP_BIT] = 1'b1;
    end
    d.sts1 = d.sts1 | s1_set;
    d.sts2 = d.sts2 | gpio_set;
    d.sts6 = d.sts6 | irq_set;

    // Summary tracks pending enabled events, blind to the global enable
    d.summary = |(d.sts1 & q.en1) | |(d.sts2 & q.en2) | |(d.sts6 & q.en6);
    d.wake_act = d.wake_ctrl[wes_pkg::CTRL_GLOBAL_EN_BIT] & d.summary;
    d.pin_level = d.wake_act ~^ d.pin_cfg[wes_pkg::PIN_POL_BIT];
    // Open drain only ever pulls low, a pull-up makes the high level
    d.pin_oe_n = ~(d.pin_cfg[wes_pkg::PIN_PUSH_PULL_BIT] | ~d.pin_level);

    d.rdata = 8'h00;
    if (i_io_rd) begin
      unique case (i_io_addr)
        wes_pkg::OFF_EDGE_SEL: d.rdata = q.edge_sel;
        wes_pkg::OFF_SCAN_CODE: d.rdata = scan_code_q;
        wes_pkg::OFF_SLEEP_LOW: d.rdata = q.sleep_low;
        wes_pkg::OFF_SLEEP_HIGH: d.rdata = {3'h0, q.sleep_type, 2'h0};
        wes_pkg::OFF_SMI_STATUS_SEVEN: d.rdata = q.smi_status_seven;
        wes_pkg::OFF_SMI_ENABLE_SEVEN: d.rdata = q.smi_enable_seven;
        wes_pkg::OFF_WAKE_CTRL: d.rdata = q.wake_ctrl | {6'h00, q.summary, 1'b0};
        wes_pkg::OFF_PIN_CFG: d.rdata = q.pin_cfg;
        wes_pkg::OFF_WAKE_STS1: d.rdata = q.sts1;
        wes_pkg::OFF_WAKE_EN1: d.rdata = q.en1;
        wes_pkg::OFF_WAKE_STS2: d.rdata = q.sts2;
        wes_pkg::OFF_WAKE_EN2: d.rdata = q.en2;
        wes_pkg::OFF_GPIO_POL: d.rdata = q.gpio_pol;
        wes_pkg::OFF_GPIO_EITHER_EDGE_TRIGGER: d.rdata = q.gpio_either_edge_trigger;
        wes_pkg::OFF_WAKE_STS6: d.rdata = q.sts6;
        wes_pkg::OFF_WAKE_EN6: d.rdata = q.en6;
        wes_pkg::OFF_SLOW_CFG: d.rdata = q.slow_cfg;
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
      q.pin_cfg <= wes_pkg::RST_PIN_CFG;
      q.pin_level <= 1'b1;
      q.pin_oe_n <= 1'b1;
      q.prev_ri <= 1'b1;
      // Port lines idle high; avoids a false edge after reset
      q.prev_la <= 1'b1;
      q.prev_lb <= 1'b1;
      q.prev_kclk <= 1'b1;
      q.kst <= wes_pkg::KEY_IDLE;
    end else if (i_clk_en) begin
      q <= d;
    end
  end

  // Scan code lives on trickle power, so only its own reset clears it
  always_ff @(posedge i_ref_clk or negedge i_trickle_resetn) begin
    if (!i_trickle_resetn) begin
      scan_code_q <= wes_pkg::RST_SCAN_CODE;
    end else if (i_clk_en && i_io_wr && i_io_addr == wes_pkg::OFF_SCAN_CODE) begin
      scan_code_q <= i_io_wdata;
    end
  end

  assign pending1 = q.sts1 & q.en1;
  assign pending2 = q.sts2 & q.en2;
  assign pending6 = q.sts6 & q.en6;
  // Port-line SMI follows the status bit, so clearing it drops the request
  assign o_smi_req = |(q.smi_status_seven & q.smi_enable_seven) |
    (q.sts1[wes_pkg::S1_LINE_A_BIT] & q.wake_ctrl[wes_pkg::CTRL_SMI_A_BIT]) |
    (q.sts1[wes_pkg::S1_LINE_B_BIT] & q.wake_ctrl[wes_pkg::CTRL_SMI_B_BIT]);
  assign o_wake_event_out = q.pin_level;
  assign o_wake_event_oe_n = q.pin_oe_n;
  assign o_io_rdata = q.rdata;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_sleep_sets_status: assert property (
    i_clk_en && i_io_wr && i_io_addr == wes_pkg::OFF_SLEEP_HIGH && i_io_wdata[5]
    |=> q.smi_status_seven[5])
    else $error("sleep enable write did not set SMI status");
  chk_smi_gated: assert property (
    q.smi_status_seven[5] && q.smi_enable_seven[5] |-> o_smi_req)
    else $error("enabled sleep status gave no SMI");
  chk_type_inert: assert property (
    i_clk_en && i_io_wr && i_io_addr == wes_pkg::OFF_SLEEP_HIGH && !i_io_wdata[5]
    |=> q.smi_status_seven[5] == $past(q.smi_status_seven[5]))
    else $error("sleep type write set SMI status");
  chk_global_gate: assert property (
    !q.wake_ctrl[0] |-> !q.wake_act)
    else $error("wake asserted with global enable off");
  chk_wake_enabled: assert property (
    q.wake_ctrl[0] && q.summary |-> q.wake_act)
    else $error("enabled wake source did not assert wake");
  chk_summary_hold: assert property (
    i_clk_en && !i_io_wr && |pending1 |=> q.summary)
    else $error("summary dropped with an event pending");
  chk_gpio_rise: assert property (
    i_clk_en && !q.gpio_either_edge_trigger[0] && !q.gpio_pol[0] && !q.prev_gpio[0] && i_gpio[0]
    |=> q.sts2[0])
    else $error("GPIO rising edge missed");
  chk_line_fall: assert property (
    i_clk_en && q.prev_la && !i_kbd_port_line_a |=> q.sts1[1])
    else $error("port line falling edge missed");
  chk_key_status: assert property (
    i_clk_en && key_hit |=> q.sts1[5])
    else $error("key match did not set status");
  chk_pin_polarity: assert property (
    !q.pin_cfg[0] && !q.pin_cfg[7] |-> o_wake_event_out == !q.wake_act)
    else $error("wake pin level wrong for active low");

  cov_sleep_smi: cover property (q.smi_status_seven[5] && o_smi_req);
  cov_key_wake: cover property (key_hit ##1 q.sts1[5]);
  cov_wake_pin: cover property (q.wake_act && !o_wake_event_oe_n);
  cov_gpio_either: cover property (q.gpio_either_edge_trigger[0] && gpio_set[0] && q.prev_gpio[0]);
endmodule : wes_wake_event_smi

// ===== verification/wes_chipset_model.sv
// Chipset side model: wake pin with board pull-up and SMI sampling
`timescale 1ns/10ps
module wes_chipset_model (
  input wire logic i_ref_clk,
  input wire logic i_pin_level,
  input wire logic i_pin_oe_n,
  input wire logic i_smi_req,
  output logic o_wake_line,
  output logic o_smi_seen
);
  // Released pin is pulled up, never a stale driven level
  assign o_wake_line = i_pin_oe_n ? 1'b1 : i_pin_level;
  always_ff @(posedge i_ref_clk) begin
    o_smi_seen <= i_smi_req;
  end
endmodule : wes_chipset_model

// ===== verification/testbench.sv
// Self-checking bench of the wake event and SMI logic
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rstn = 0, trstn = 0, rd = 0, wr = 0, ring_n = 1, la = 1, lb = 1;
  logic wdt = 0, tach = 0, kclk = 1, kdat = 1, sext = 0, ext_run = 0;
  logic [7:0] addr = 0, wd = 0, gpio = 0, irq = 0, rdata, sc, kc;
  logic smi, pin, oe_n, line, smi_seen;
  logic [4:0] ev;
  int m [256];
  int failures = 0, total_checks = 0, cyc = 0, g;

  wes_wake_event_smi #(.DIV_CYCLES(4)) u_dut (
    .i_ref_clk(clk), .i_resetn(rstn), .i_trickle_resetn(trstn), .i_clk_en(1'b1),
    .i_io_addr(addr), .i_io_wr(wr), .i_io_rd(rd), .i_io_wdata(wd), .o_io_rdata(rdata),
    .i_ring_indicator_in_n(ring_n), .i_kbd_port_line_a(la), .i_kbd_port_line_b(lb),
    .i_wdt_timeout(wdt), .i_fan_tach_event(tach), .i_gpio(gpio), .i_dev_irq(irq),
    .i_kbd_clk(kclk), .i_kbd_data(kdat), .i_slow_clk_ext(sext), .o_smi_req(smi),
    .o_wake_event_out(pin), .o_wake_event_oe_n(oe_n)
  );
  wes_chipset_model u_chipset (
    .i_ref_clk(clk), .i_pin_level(pin), .i_pin_oe_n(oe_n), .i_smi_req(smi),
    .o_wake_line(line), .o_smi_seen(smi_seen)
  );

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Free-running external slow clock once enabled; hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ext_run && cyc % 3 == 0) begin
      sext <= ~sext;
    end
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic summ();
    return |((m[8'h6a] & m[8'h6b]) | (m[8'h6c] & m[8'h6d]) | (m[8'h70] & m[8'h71]));
  endfunction : summ

  task automatic wreg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    case (a)
      8'h64, 8'h6a, 8'h6c, 8'h70: m[a] = m[a] & ~d;
      8'h61: begin
        m[a] = d & 8'hdf;
        m[8'h64] = m[8'h64] | (d & 8'h20);
      end
      8'h68: m[a] = d & 8'h0d;
      8'h21, 8'h5f, 8'h60, 8'h66, 8'h69, 8'h6b, 8'h6d, 8'h6e, 8'h6f, 8'h71, 8'hf0: m[a] = d;
      default: ;
    endcase
  endtask : wreg

  task automatic rchk(logic [7:0] a, string nm);
    int e;
    e = (a == 8'h68) ? (m[a] | (summ() << 1)) : m[a];
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, e[7:0]);
  endtask : rchk

  task automatic outs();
    logic act, lvl, s;
    repeat (3) @(posedge clk);
    act = summ() & m[8'h68][0];
    lvl = m[8'h69][0] ? act : !act;
    s = (m[8'h64][5] & m[8'h66][5]) | (m[8'h6a][1] & m[8'h68][2]);
    s = s | (m[8'h6a][2] & m[8'h68][3]);
    #1;
    chk("wake line", line, lvl);
    chk("wake oe_n", oe_n, m[8'h69][7] ? 1'b0 : lvl);
    chk("smi", smi_seen, s);
  endtask : outs

  // Keyboard clock idles high; each half bit spans several slow ticks
  task automatic kframe(logic [7:0] code, logic badpar);
    logic [10:0] f;
    f = {1'b1, (~^code) ^ badpar, code, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk) kdat <= f[i];
      repeat (16) @(posedge clk);
      kclk <= 1'b0;
      repeat (16) @(posedge clk);
      kclk <= 1'b1;
    end
    repeat (40) @(posedge clk);
    kdat <= 1'b1;
  endtask : kframe

  initial begin
    void'($urandom(55944));
    for (int i = 0; i < 256; i++) m[i] = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    trstn <= 1'b1;
    outs();
    rchk(8'h6a, "wake sts1");
    sc = 8'($urandom);
    wreg(8'h60, sc);
    wreg(8'h61, 8'h1c);
    rchk(8'h60, "sleep low");
    rchk(8'h61, "sleep high");
    outs();
    wreg(8'h61, 8'h3c);
    rchk(8'h64, "smi_status_seven");
    outs();
    wreg(8'h66, 8'h20);
    outs();
    wreg(8'h64, 8'h20);
    outs();
    g = $urandom_range(7);
    wreg(8'h6d, 8'h01 << g);
    wreg(8'h71, 8'h01);
    @(posedge clk) gpio[g] <= 1'b1;
    m[8'h6c] |= 1 << g;
    outs();
    rchk(8'h68, "wake ctrl");
    wreg(8'h68, 8'h01);
    outs();
    wreg(8'h69, 8'h81);
    outs();
    @(posedge clk) irq[0] <= 1'b1;
    m[8'h70] |= 1;
    wreg(8'h6c, 8'h00);
    outs();
    wreg(8'h6c, 8'hff);
    outs();
    wreg(8'h70, 8'h01);
    outs();
    wreg(8'h69, 8'h80);
    wreg(8'h6f, 8'h01 << g);
    @(posedge clk) gpio[g] <= 1'b0;
    m[8'h6c] |= 1 << g;
    outs();
    wreg(8'h6c, 8'hff);
    wreg(8'h6f, 8'h00);
    wreg(8'h6e, 8'h01 << g);
    @(posedge clk) gpio[g] <= 1'b1;
    outs();
    @(posedge clk) gpio[g] <= 1'b0;
    m[8'h6c] |= 1 << g;
    outs();
    rchk(8'h6c, "inverted gpio");
    wreg(8'h6c, 8'hff);
    wreg(8'h6b, 8'h3f);
    wreg(8'h68, 8'h0d);
    ev = 5'b00111;
    for (int i = 0; i < 5; i++) begin
      ev[i] = ~ev[i];
      @(posedge clk) {tach, wdt, lb, la, ring_n} <= ev;
      m[8'h6a] |= 1 << i;
      outs();
      rchk(8'h6a, "wake sts1");
      wreg(8'h6a, 8'h01 << i);
      outs();
    end
    wreg(8'h21, 8'h01);
    @(posedge clk) {lb, la} <= 2'b11;
    m[8'h6a] |= 2;
    outs();
    rchk(8'h6a, "both edges");
    wreg(8'h6a, 8'h02);
    kc = 8'($urandom);
    wreg(8'h5f, kc);
    kframe(kc, 1'b0);
    m[8'h6a] |= 8'h20;
    outs();
    wreg(8'h6a, 8'h20);
    kframe(kc, 1'b1);
    rchk(8'h6a, "bad parity");
    wreg(8'hf0, 8'h02);
    kframe(kc, 1'b0);
    rchk(8'h6a, "key off");
    wreg(8'hf0, 8'h01);
    kframe(kc, 1'b0);
    rchk(8'h6a, "no ext clk");
    ext_run <= 1'b1;
    kframe(kc, 1'b0);
    m[8'h6a] |= 8'h20;
    rchk(8'h6a, "ext clk");
    // Inputs return to idle inside reset so release sees no edges
    @(posedge clk) begin
      rstn <= 1'b0;
      {tach, wdt, lb, la, ring_n} <= 5'b00111;
      gpio <= 8'h00;
      irq <= 8'h00;
    end
    for (int i = 0; i < 256; i++) m[i] = (i == 8'h5f) ? m[i] : 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    outs();
    rchk(8'h5f, "scan code kept");
    @(posedge clk) trstn <= 1'b0;
    repeat (2) @(posedge clk);
    trstn <= 1'b1;
    m[8'h5f] = 0;
    rchk(8'h5f, "scan code cleared");
    give_verdict();
  end
endmodule : testbench
